// File: verilog/i2c_script_pkg.sv
// Shared constants and types for the scripted I2C master engine
package i2c_script_pkg;
  // Script command codes
  typedef enum logic [2:0] {
    ACK_POLL_TIMEOUT_CMD,
    ADDRESS_READ_CMD,
    ADDRESS_WRITE_CMD,
    BUS_RATE_CMD,
    WAIT_CMD,
    LINE_DIRECTION_CMD
  } cmdOp_t;
  // Engine states on the core clock
  typedef enum {CORE_IDLE, CORE_READY, CORE_ADDR, CORE_DELAY} coreState_t;
  // Link-side bit engine states
  typedef enum {LINK_IDLE, LINK_RESTART, LINK_BITS, LINK_DONE} linkState_t;
  // Core clock and millisecond tick
  localparam int CORE_PERIOD_NS = 5;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CORE_PERIOD_NS;
  localparam int MS_CNT_W = 18;
  // Link clock rate, used to derive bit quarter counts
  localparam int LINK_PERIOD_PS = 15000;
  localparam int LINK_KHZ = 1000000000 / LINK_PERIOD_PS;
  // Supported bus rates in kHz, highest first
  localparam int NUM_RATES = 4;
  localparam int RATE_IW = 2;
  localparam logic [15:0] RATE_KHZ [NUM_RATES] = '{16'h03E8, 16'h0190, 16'h00FA, 16'h0064};
  localparam logic [RATE_IW-1:0] RATE_IDX_RESET = 2'h3;
  // Values taken after reset or at the end of a script
  localparam logic [15:0] ACK_TIMEOUT_RESET = 16'h0000;
  localparam logic [7:0] DIO_DIR_RESET = 8'h00;
  // Direction bit of the address byte
  localparam logic DIR_READ = 1'b1;
  localparam logic DIR_WRITE = 1'b0;
  // Line configuration values
  localparam logic DIRECTION_IN = 1'b0;
  localparam logic DIRECTION_OUT = 1'b1;
  // Address byte plus acknowledge slot
  localparam logic [3:0] ACK_SLOT = 4'h8;
endpackage

// File: verilog/i2c_addr_link.sv
// Link-clock bit engine: optional repeated start, address byte, acknowledge sample
`timescale 1ns/1ps
module i2c_addr_link
  import i2c_script_pkg::*;
(
  // Link clock and reset
  input wire logic linkClk,
  input wire logic nrst,
  input wire logic ce,
  // Request from the core, toggle plus stable data
  input wire logic reqTgl,
  input wire logic [7:0] addrByte,
  input wire logic withRestart,
  input wire logic [15:0] quarterDiv,
  // Answer to the core, toggle plus stable result
  output logic ackTgl,
  output logic acked,
  // Open-drain bus lines, enable high means pulling low
  output logic sclOe,
  output logic sdaOe,
  input wire logic sdaIn
);
  import i2c_script_pkg::*;

  // All link-side state
  typedef struct packed {
    linkState_t st;
    logic rstS1;
    logic rstS2;
    logic reqS1;
    logic reqS2;
    logic reqSeen;
    logic ceS1;
    logic ceS2;
    logic sdaS1;
    logic sdaS2;
    logic [15:0] q;
    logic [1:0] phase;
    logic [3:0] bitIdx;
    logic [7:0] sh;
    logic sclLow;
    logic sdaLow;
    logic ackTgl;
    logic acked;
  } linkReg_t;

  linkReg_t r;
  linkReg_t next_r;
  logic quarterEnd;

  // Quarter of a bit period has elapsed
  assign quarterEnd = (r.q == quarterDiv);

  // Next state: synchronisers always run, the rest waits for the enable
  always_comb
  begin
    next_r = r;
    next_r.rstS1 = nrst;
    next_r.rstS2 = r.rstS1;
    next_r.reqS1 = reqTgl;
    next_r.reqS2 = r.reqS1;
    next_r.ceS1 = ce;
    next_r.ceS2 = r.ceS1;
    next_r.sdaS1 = sdaIn;
    next_r.sdaS2 = r.sdaS1;
    if (r.ceS2)
    begin
      next_r.q = quarterEnd ? 16'h0000 : r.q + 16'h0001;
      unique case (r.st)
        LINK_IDLE:
        begin
          next_r.q = 16'h0000;
          next_r.phase = 2'h0;
          if (r.reqS2 != r.reqSeen)
          begin
            // Only the second flop is compared, the first feeds it alone
            next_r.reqSeen = r.reqS2;
            next_r.sh = addrByte;
            next_r.bitIdx = 4'h0;
            // An earlier start leaves the clock low; hold it so data never moves under it
            next_r.sclLow = 1'b1;
            next_r.st = withRestart ? LINK_RESTART : LINK_BITS;
          end
        end
        LINK_RESTART:
        begin
          // Release both lines, then pull data low while clock is high
          if (quarterEnd)
          begin
            next_r.phase = r.phase + 2'h1;
            unique case (r.phase)
              2'h0: next_r.sdaLow = 1'b0;
              2'h1: next_r.sclLow = 1'b0;
              2'h2: next_r.sdaLow = 1'b1;
              2'h3:
              begin
                next_r.sclLow = 1'b1;
                next_r.st = LINK_BITS;
              end
            endcase
          end
        end
        LINK_BITS:
        begin
          if (quarterEnd)
          begin
            next_r.phase = r.phase + 2'h1;
            unique case (r.phase)
              2'h0:
              begin
                // Data changes while the clock is low; data line free at slot 8
                next_r.sclLow = 1'b1;
                next_r.sdaLow = (r.bitIdx == ACK_SLOT) ? 1'b0 : ~r.sh[7];
              end
              2'h1: next_r.sclLow = 1'b0;
              2'h2: next_r.sclLow = 1'b0;
              2'h3:
              begin
                next_r.sclLow = 1'b1;
                next_r.sh = {r.sh[6:0], 1'b0};
                next_r.bitIdx = r.bitIdx + 4'h1;
                if (r.bitIdx == ACK_SLOT)
                begin
                  // Slave pulls data low to acknowledge
                  next_r.acked = ~r.sdaS2;
                  next_r.st = LINK_DONE;
                end
              end
            endcase
          end
        end
        LINK_DONE:
        begin
          // Clock stays low, holding the bus for the next command
          next_r.ackTgl = ~r.ackTgl;
          next_r.st = LINK_IDLE;
        end
      endcase
    end
  end

  // State register; the reset pin is re-timed by two flops before it acts here
  always_ff @(posedge linkClk)
  begin
    if (!r.rstS2)
    begin
      r <= '0;
      r.st <= LINK_IDLE;
      r.rstS1 <= next_r.rstS1;
      r.rstS2 <= next_r.rstS2;
    end
    else
      r <= next_r;
  end

  // Outputs straight from flops
  assign ackTgl = r.ackTgl;
  assign acked = r.acked;
  assign sclOe = r.sclLow;
  assign sdaOe = r.sdaLow;
endmodule

// File: verilog/i2c_script_master.sv
// Scripted I2C master engine: address, poll timeout, rate, delay and line commands
`timescale 1ns/1ps
module i2c_script_master
  import i2c_script_pkg::*;
#(
  parameter int NUM_I2C = 2,
  parameter int NUM_DIO = 1,
  parameter int MS_TICKS = MS_CYCLES
)
(
  // Core clock, reset and enable
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  // Link clock for the bit engine
  input wire logic linkClk,
  // Script control
  input wire logic launchScript,
  input wire logic [7:0] launchPort,
  input wire logic scriptEnd,
  input wire logic busStarted,
  // Command stream
  input wire logic cmdValid,
  output logic cmdReady,
  input wire i2c_script_pkg::cmdOp_t cmdOp,
  input wire logic [15:0] cmdArg,
  input wire logic [7:0] portIndex,
  input wire logic [2:0] lineIndex,
  // Status
  output logic running,
  output logic errFlag,
  output logic warnFlag,
  output logic [15:0] rateKhz,
  output logic [NUM_DIO-1:0][7:0] lineDirection,
  // Open-drain I2C pins, one set per port
  output logic [NUM_I2C-1:0] sclO,
  output logic [NUM_I2C-1:0] sclOe,
  output logic [NUM_I2C-1:0] sdaO,
  output logic [NUM_I2C-1:0] sdaOe,
  input wire logic [NUM_I2C-1:0] sdaI
);
  import i2c_script_pkg::*;

  localparam int PW = (NUM_I2C > 1) ? $clog2(NUM_I2C) : 1;
  localparam logic [MS_CNT_W-1:0] MS_LAST = MS_CNT_W'(MS_TICKS - 1);

  // All core-side state
  typedef struct packed {
    coreState_t st;
    logic running;
    logic [PW-1:0] port;
    logic [15:0] ackTimeout;
    logic pollOn;
    logic [MS_CNT_W-1:0] cyc;
    logic [15:0] msCnt;
    logic [15:0] msTarget;
    logic [7:0] addrByte;
    logic withRestart;
    logic reqTgl;
    logic ackS1;
    logic ackS2;
    logic ackSeen;
    logic errFlag;
    logic warnFlag;
    logic [NUM_I2C-1:0][RATE_IW-1:0] rateIdx;
    logic [NUM_DIO-1:0][7:0] dioDir;
  } coreReg_t;

  coreReg_t r;
  coreReg_t next_r;
  logic cmdFire;
  logic msTick;
  logic linkAckTgl;
  logic linkAcked;
  logic linkScl;
  logic linkSda;
  logic [RATE_IW-1:0] fitIdx;
  logic fitFound;
  logic fitExact;
  logic [15:0] quarterDiv;

  // Highest supported rate not above the request
  always_comb
  begin
    fitIdx = '0;
    fitFound = 1'b0;
    fitExact = 1'b0;
    for (int i = NUM_RATES - 1; i >= 0; i--)
    begin
      if (RATE_KHZ[i] <= cmdArg)
      begin
        fitIdx = RATE_IW'(i);
        fitFound = 1'b1;
        fitExact = (RATE_KHZ[i] == cmdArg);
      end
    end
  end

  // Quarter-bit count for the launched port; constants only, no divider in logic
  always_comb
  begin
    quarterDiv = 16'h0001;
    for (int i = 0; i < NUM_RATES; i++)
      if (r.rateIdx[r.port] == RATE_IW'(i))
        quarterDiv = 16'(LINK_KHZ / (4 * int'(RATE_KHZ[i])));
  end

  assign cmdFire = cmdValid && cmdReady;
  assign msTick = (r.cyc == MS_LAST);

  // Command engine next state
  always_comb
  begin
    next_r = r;
    next_r.ackS1 = linkAckTgl;
    next_r.ackS2 = r.ackS1;
    next_r.cyc = msTick ? '0 : r.cyc + MS_CNT_W'(1);
    if (msTick)
      next_r.msCnt = r.msCnt + 16'h0001;
    unique case (r.st)
      CORE_IDLE:
      begin
        if (launchScript)
        begin
          // Port fixed for the whole run
          next_r.port = PW'(launchPort);
          next_r.running = 1'b1;
          next_r.errFlag = 1'b0;
          next_r.warnFlag = 1'b0;
          next_r.st = CORE_READY;
        end
      end
      CORE_READY:
      begin
        if (scriptEnd)
        begin
          // Timeout returns to default at the end of the run
          next_r.ackTimeout = ACK_TIMEOUT_RESET;
          next_r.running = 1'b0;
          next_r.st = CORE_IDLE;
        end
        else if (cmdFire)
        begin
          next_r.cyc = '0;
          next_r.msCnt = 16'h0000;
          unique case (cmdOp)
            ACK_POLL_TIMEOUT_CMD:
              next_r.ackTimeout = cmdArg; // 16-bit milliseconds, kept for later commands
            ADDRESS_READ_CMD, ADDRESS_WRITE_CMD:
            begin
              // Address plus direction bit, no start of our own
              next_r.addrByte = {cmdArg[6:0],
                (cmdOp == ADDRESS_READ_CMD) ? DIR_READ : DIR_WRITE};
              next_r.withRestart = 1'b0;
              // Polling only with a nonzero timeout behind a start
              next_r.pollOn = (r.ackTimeout != 16'h0000) && busStarted;
              next_r.reqTgl = ~r.reqTgl;
              next_r.st = CORE_ADDR;
            end
            BUS_RATE_CMD:
            begin
              if (!fitFound)
                next_r.errFlag = 1'b1; // Below every supported rate
              else
              begin
                // Rate of the launched port, rounded down if needed
                next_r.rateIdx[r.port] = fitIdx;
                if (!fitExact)
                  next_r.warnFlag = 1'b1;
              end
            end
            WAIT_CMD:
            begin
              // Idle for the milliseconds given in the low argument byte before the next command
              next_r.msTarget = {8'h00, cmdArg[7:0]};
              if (cmdArg[7:0] != 8'h00)
                next_r.st = CORE_DELAY;
            end
            LINE_DIRECTION_CMD:
            begin
              // Port index selects the digital port; unknown index is an error
              if (portIndex < 8'(NUM_DIO))
                next_r.dioDir[portIndex] [lineIndex] = cmdArg[0];
              else
                next_r.errFlag = 1'b1;
            end
          endcase
        end
      end
      CORE_ADDR:
      begin
        if (r.ackS2 != r.ackSeen)
        begin
          next_r.ackSeen = r.ackS2;
          if (linkAcked)
            next_r.st = CORE_READY;
          else if (r.pollOn && (r.msCnt < r.ackTimeout))
          begin
            // Retry under a repeated start until acknowledged or expired
            next_r.withRestart = 1'b1;
            next_r.reqTgl = ~r.reqTgl;
          end
          else
          begin
            // No acknowledge: flag and abort the run
            next_r.errFlag = 1'b1;
            next_r.running = 1'b0;
            next_r.ackTimeout = ACK_TIMEOUT_RESET;
            next_r.st = CORE_IDLE;
          end
        end
      end
      CORE_DELAY:
      begin
        if (msTick && (r.msCnt + 16'h0001 == r.msTarget))
          next_r.st = CORE_READY;
      end
    endcase
  end

  // State register; the enable freezes everything
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      r <= '0;
      r.st <= CORE_IDLE;
      r.ackTimeout <= ACK_TIMEOUT_RESET;
      r.rateIdx <= {NUM_I2C{RATE_IDX_RESET}};
      r.dioDir <= {NUM_DIO{DIO_DIR_RESET}};
    end
    else if (ce)
      r <= next_r;
  end

  // Bit engine on the link clock; toggle handshake across domains
  i2c_addr_link u_link (
    .linkClk(linkClk),
    .nrst(nrst),
    .ce(ce),
    .reqTgl(r.reqTgl),
    .addrByte(r.addrByte),
    .withRestart(r.withRestart),
    .quarterDiv(quarterDiv),
    .ackTgl(linkAckTgl),
    .acked(linkAcked),
    .sclOe(linkScl),
    .sdaOe(linkSda),
    .sdaIn(sdaI[r.port])
  );

  // Pins of the launched port only; port changes only between runs
  for (genvar p = 0; p < NUM_I2C; p++)
  begin : g_pin
    assign sclO[p] = 1'b0;
    assign sdaO[p] = 1'b0;
    assign sclOe[p] = linkScl && (r.port == PW'(p));
    assign sdaOe[p] = linkSda && (r.port == PW'(p));
  end

  // Status outputs
  assign cmdReady = ce && (r.st == CORE_READY) && !scriptEnd;
  assign running = r.running;
  assign errFlag = r.errFlag;
  assign warnFlag = r.warnFlag;
  assign rateKhz = RATE_KHZ[r.rateIdx[r.port]];
  assign lineDirection = r.dioDir;

  // Checks
  property p_poll_off;
    @(posedge core_clk) disable iff (!nrst)
    (ce && cmdFire && (cmdOp inside {ADDRESS_READ_CMD, ADDRESS_WRITE_CMD})
      && r.ackTimeout == 16'h0000) |=> !r.pollOn;
  endproperty
  a_poll_off: assert property (p_poll_off) else $error("polling on with zero timeout");

  property p_retry;
    @(posedge core_clk) disable iff (!nrst)
    (ce && r.st == CORE_ADDR && r.ackS2 != r.ackSeen && !linkAcked && r.pollOn
      && r.msCnt < r.ackTimeout) |=> (r.st == CORE_ADDR && r.withRestart && $changed(r.reqTgl));
  endproperty
  a_retry: assert property (p_retry) else $error("nack not retried");

  property p_need_start;
    @(posedge core_clk) disable iff (!nrst)
    (ce && cmdFire && cmdOp == ADDRESS_WRITE_CMD && !busStarted) |=> !r.pollOn;
  endproperty
  a_need_start: assert property (p_need_start) else $error("poll without start");

  property p_end_reset;
    @(posedge core_clk) disable iff (!nrst)
    (ce && r.st == CORE_READY && scriptEnd) |=> (r.ackTimeout == ACK_TIMEOUT_RESET && !running);
  endproperty
  a_end_reset: assert property (p_end_reset) else $error("timeout kept after end");

  property p_read_bit;
    @(posedge core_clk) disable iff (!nrst)
    (ce && cmdFire && cmdOp == ADDRESS_READ_CMD)
      |=> (r.addrByte == {$past(cmdArg[6:0]), 1'b1} && !r.withRestart);
  endproperty
  a_read_bit: assert property (p_read_bit) else $error("read address byte wrong");

  property p_write_bit;
    @(posedge core_clk) disable iff (!nrst)
    (ce && cmdFire && cmdOp == ADDRESS_WRITE_CMD) |=> (r.addrByte[0] == 1'b0);
  endproperty
  a_write_bit: assert property (p_write_bit) else $error("write direction bit wrong");

  property p_rate_low;
    @(posedge core_clk) disable iff (!nrst)
    (ce && cmdFire && cmdOp == BUS_RATE_CMD && cmdArg < RATE_KHZ[NUM_RATES-1])
      |=> (errFlag && $stable(r.rateIdx));
  endproperty
  a_rate_low: assert property (p_rate_low) else $error("low rate not rejected");

  property p_line_dir;
    @(posedge core_clk) disable iff (!nrst)
    (ce && cmdFire && cmdOp == LINE_DIRECTION_CMD && portIndex == 8'h00)
      |=> (lineDirection[0][$past(lineIndex)] == $past(cmdArg[0]));
  endproperty
  a_line_dir: assert property (p_line_dir) else $error("line direction not set");

  property p_delay_hold;
    @(posedge core_clk) disable iff (!nrst)
    (ce && cmdFire && cmdOp == WAIT_CMD && cmdArg[7:0] != 8'h00) |=> !cmdReady [*8];
  endproperty
  a_delay_hold: assert property (p_delay_hold) else $error("delay not held");

  c_retry: cover property (@(posedge core_clk) disable iff (!nrst)
    r.st == CORE_ADDR && r.withRestart);
  c_abort: cover property (@(posedge core_clk) disable iff (!nrst)
    $fell(running) && errFlag);
  c_warn: cover property (@(posedge core_clk) disable iff (!nrst) $rose(warnFlag));
endmodule

// File: tb/i2c_slave_model.sv
// Behavioural I2C slave that acknowledges its address after a set number of refusals
`timescale 1ns/1ps
module i2c_slave_model
(
  // Wire levels of the bus
  input wire logic scl,
  input wire logic sda,
  // Bench control
  input wire logic rstN,
  input wire logic [6:0] ownAddr,
  input wire logic [7:0] nackFirst,
  // Pull-down on the data line and what was observed
  output logic pull,
  output logic [7:0] byteSeen,
  output logic [7:0] attempts,
  output logic [7:0] restarts
);
  logic [3:0] bitCnt; // Bits taken in this frame, 8 marks the acknowledge slot
  logic [7:0] shifter; // Address bits, MSB first
  logic [7:0] rsUsed; // Restarts already folded into the bit count
  // Data falling while the clock is high marks a (repeated) start
  always @(negedge sda or negedge rstN)
    if (!rstN)
      restarts <= 8'h00;
    else if (scl)
      restarts <= restarts + 8'h01;
  // Bits are taken as the clock rises; a clock fall that ends a start carries none
  always @(posedge scl or negedge rstN)
    if (!rstN)
    begin
      bitCnt <= 4'h0;
      attempts <= 8'h00;
      rsUsed <= 8'h00;
      byteSeen <= 8'h00;
      shifter <= 8'h00;
    end
    else if (restarts != rsUsed)
    begin
      // The high pulse of a restart was taken as a bit; start over with this one
      rsUsed <= restarts;
      shifter <= {7'h00, sda};
      bitCnt <= 4'h1;
    end
    else if (bitCnt < 4'h8)
    begin
      shifter <= {shifter[6:0], sda};
      bitCnt <= bitCnt + 4'h1;
      if (bitCnt == 4'h7)
        byteSeen <= {shifter[6:0], sda};
    end
    else
    begin
      // High pulse of the acknowledge slot ends the frame
      bitCnt <= 4'h0;
      attempts <= attempts + 8'h01;
    end
  // Acknowledge set up and released only while the clock is low
  always @(negedge scl or negedge rstN)
    if (!rstN)
      pull <= 1'b0;
    else
      pull <= (bitCnt == 4'h8) && (byteSeen[7:1] == ownAddr) && (attempts >= nackFirst);
endmodule

// File: tb/i2c_script_master_tb_top.sv
// Self-checking bench for the scripted I2C master engine
`timescale 1ns/1ps
module i2c_script_master_tb_top;
  import i2c_script_pkg::*;
  // Clocks, reset and script control
  logic core_clk = 1'b0;
  logic linkClk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic launchScript = 1'b0;
  logic [7:0] launchPort = 8'h01;
  logic scriptEnd = 1'b0;
  logic busStarted = 1'b1;
  // Command stream
  logic cmdValid = 1'b0;
  logic cmdReady;
  cmdOp_t cmdOp = ACK_POLL_TIMEOUT_CMD;
  logic [15:0] cmdArg = 16'h0000;
  logic [7:0] portIndex = 8'h00;
  logic [2:0] lineIndex = 3'h0;
  // Status and pins
  logic running, errFlag, warnFlag;
  logic [15:0] rateKhz;
  logic [0:0][7:0] lineDirection;
  logic [1:0] sclO, sclOe, sdaO, sdaOe, sdaI;
  // Slave side and bookkeeping
  logic slvRstN = 1'b0;
  logic [7:0] nackFirst = 8'h00;
  logic pull;
  logic [7:0] byteSeen, attempts, restarts;
  logic stray = 1'b0;
  int errTotal = 0;
  int checksDone = 0;
  // Open-drain wires with pull-ups; only port 1 has a slave
  assign sdaI = {~(sdaOe[1] | pull), ~sdaOe[0]};
  always #2.5 core_clk = ~core_clk;
  // Link clock offset so its edges never line up with the core clock
  initial
  begin
    #1.3;
    forever #7.5 linkClk = ~linkClk;
  end
  i2c_script_master #(.NUM_I2C(2), .NUM_DIO(1), .MS_TICKS(20)) u_dut (
    .core_clk(core_clk), .nrst(nrst), .ce(ce), .linkClk(linkClk),
    .launchScript(launchScript), .launchPort(launchPort), .scriptEnd(scriptEnd),
    .busStarted(busStarted), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdOp(cmdOp),
    .cmdArg(cmdArg), .portIndex(portIndex), .lineIndex(lineIndex), .running(running),
    .errFlag(errFlag), .warnFlag(warnFlag), .rateKhz(rateKhz),
    .lineDirection(lineDirection), .sclO(sclO), .sclOe(sclOe), .sdaO(sdaO),
    .sdaOe(sdaOe), .sdaI(sdaI));
  i2c_slave_model u_slave (.scl(~sclOe[1]), .sda(sdaI[1]), .rstN(slvRstN),
    .ownAddr(7'h2B), .nackFirst(nackFirst), .pull(pull), .byteSeen(byteSeen),
    .attempts(attempts), .restarts(restarts));
  // Unused port must stay silent; master must free data while the acknowledge is sampled
  always @(posedge core_clk)
    if (sclOe[0] | sdaOe[0] | (pull & sdaOe[1] & ~sclOe[1]))
      stray <= 1'b1;
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checksDone++;
    if (got !== exp)
    begin
      errTotal++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // Bounded wait until the engine takes commands again or the run stops
  task automatic waitReady(input int limit, output int n);
    n = 0;
    while (cmdReady !== 1'b1 && running === 1'b1 && n < limit)
    begin
      tick(1);
      n++;
    end
    if (n >= limit)
      chk("ready bound", 16'h0001, 16'h0000);
  endtask
  // Holds the command until the edge at which ready is high
  task automatic issue(input cmdOp_t op, input logic [15:0] arg);
    int n;
    int w;
    cmdOp = op;
    cmdArg = arg;
    cmdValid = 1'b1;
    waitReady(200, n);
    tick(1);
    cmdValid = 1'b0;
    waitReady(40000, w);
  endtask
  task automatic launch();
    int n;
    launchScript = 1'b1;
    tick(1);
    launchScript = 1'b0;
    waitReady(20, n);
  endtask
  task automatic endScript();
    if (running === 1'b1)
    begin
      scriptEnd = 1'b1;
      tick(1);
      scriptEnd = 1'b0;
      tick(1);
    end
  endtask
  // Fast rate, optional poll timeout, then one address command on port 1
  task automatic addrRun(input cmdOp_t op, input logic [6:0] a, input logic [15:0] tmo,
    input logic started, input logic [7:0] nacks);
    launch();
    issue(BUS_RATE_CMD, 16'h03E8);
    if (tmo != 16'h0000)
      issue(ACK_POLL_TIMEOUT_CMD, tmo);
    nackFirst = nacks;
    busStarted = started;
    slvRstN = 1'b0;
    tick(1);
    slvRstN = 1'b1;
    issue(op, {9'h000, a});
  endtask
  task automatic tRate();
    logic [15:0] rq [8] = '{16'h03E8, 16'h0190, 16'h00FA, 16'h0064, 16'h02BC, 16'h0096,
      16'h0063, 16'hFFFF};
    logic [15:0] ex [8] = '{16'h03E8, 16'h0190, 16'h00FA, 16'h0064, 16'h0190, 16'h0064,
      16'h0064, 16'h03E8};
    logic [1:0] fl [8] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h1};
    chk("reset rate", 16'h0064, rateKhz);
    for (int i = 0; i < 8; i++)
    begin
      launch();
      issue(BUS_RATE_CMD, rq[i]);
      chk("rate", ex[i], rateKhz);
      chk("rate warn", {15'h0000, fl[i][0]}, {15'h0000, warnFlag});
      chk("rate err", {15'h0000, fl[i][1]}, {15'h0000, errFlag});
      endScript();
    end
  endtask
  task automatic tAddr(input cmdOp_t op, input logic [7:0] expByte);
    addrRun(op, 7'h2B, 16'h0000, 1'b1, 8'h00);
    chk("address byte", {8'h00, expByte}, {8'h00, byteSeen});
    chk("single frame", 16'h0001, {8'h00, attempts});
    chk("no start", 16'h0000, {8'h00, restarts});
    chk("acked ok", 16'h0002, {14'h0000, running, errFlag});
    endScript();
  endtask
  task automatic tPoll();
    addrRun(ADDRESS_WRITE_CMD, 7'h2B, 16'h07D0, 1'b1, 8'h02);
    chk("poll tries", 16'h0003, {8'h00, attempts});
    chk("poll restarts", 16'h0002, {8'h00, restarts});
    chk("poll ok", 16'h0002, {14'h0000, running, errFlag});
    endScript();
    // Next script starts with polling back off
    addrRun(ADDRESS_WRITE_CMD, 7'h2B, 16'h0000, 1'b1, 8'h01);
    chk("default tries", 16'h0001, {8'h00, attempts});
    chk("nack abort", 16'h0001, {14'h0000, running, errFlag});
  endtask
  task automatic tNoStart();
    addrRun(ADDRESS_READ_CMD, 7'h2B, 16'h07D0, 1'b0, 8'h01);
    chk("no poll tries", 16'h0001, {8'h00, attempts});
    chk("no poll abort", 16'h0001, {14'h0000, running, errFlag});
  endtask
  task automatic tExpire();
    addrRun(ADDRESS_READ_CMD, 7'h2B, 16'h012C, 1'b1, 8'hC8);
    chk("retried", 16'h0001, {15'h0000, attempts > 8'h01});
    chk("restart each", {8'h00, attempts - 8'h01}, {8'h00, restarts});
    chk("expire abort", 16'h0001, {14'h0000, running, errFlag});
  endtask
  task automatic tWait();
    int n;
    logic [7:0] ms [3] = '{8'h00, 8'h03, 8'h07};
    launch();
    for (int i = 0; i < 3; i++)
    begin
      cmdOp = WAIT_CMD;
      cmdArg = {8'h00, ms[i]};
      cmdValid = 1'b1;
      waitReady(20, n);
      tick(1);
      cmdValid = 1'b0;
      waitReady(400, n);
      chk("wait low", 16'h0001, {15'h0000, n + 1 >= ms[i] * 20});
      chk("wait high", 16'h0001, {15'h0000, n <= ms[i] * 20 + 3});
    end
    endScript();
  endtask
  task automatic tLine();
    launch();
    lineIndex = 3'h3;
    issue(LINE_DIRECTION_CMD, {15'h0000, DIRECTION_OUT});
    lineIndex = 3'h6;
    issue(LINE_DIRECTION_CMD, {15'h0000, DIRECTION_OUT});
    chk("two outputs", 16'h0048, {8'h00, lineDirection[0]});
    lineIndex = 3'h3;
    issue(LINE_DIRECTION_CMD, {15'h0000, DIRECTION_IN});
    chk("back to input", 16'h0040, {8'h00, lineDirection[0]});
    portIndex = 8'h01;
    issue(LINE_DIRECTION_CMD, {15'h0000, DIRECTION_OUT});
    chk("bad port err", 16'h0001, {15'h0000, errFlag});
    chk("bad port kept", 16'h0040, {8'h00, lineDirection[0]});
    portIndex = 8'h00;
    endScript();
  endtask
  task automatic results();
    if (errTotal == 0 && checksDone > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Main sequence; five reset cycles, the link side re-times the release itself
  initial
  begin
    tick(5);
    nrst = 1'b1;
    slvRstN = 1'b1;
    tick(1);
    tRate();
    tAddr(ADDRESS_WRITE_CMD, 8'h56);
    tAddr(ADDRESS_READ_CMD, 8'h57);
    tPoll();
    tNoStart();
    tExpire();
    tWait();
    tLine();
    chk("other port quiet", 16'h0000, {15'h0000, stray});
    chk("pin drive levels", 16'h0000, {12'h000, sclO, sdaO});
    results();
  end
  // Watchdog well beyond the expected run length
  initial
  begin
    #450000;
    errTotal++;
    results();
  end
endmodule
